// ==== rtl/psf_consts.vh ====
// Constants for the per-phase status flag block.
// Included by every design file of the block; holds definitions only.
`ifndef PSF_CONSTS_VH
`define PSF_CONSTS_VH
`define PSF_ADDR_LINE_FREQ 12'h062
`define PSF_ADDR_A_FLAGS 12'h144
`define PSF_ADDR_A_ENABLE 12'h145
`define PSF_ADDR_A_WRAP 12'h146
`define PSF_ADDR_B_FLAGS 12'h230
`define PSF_ADDR_B_ENABLE 12'h231
`define PSF_ADDR_B_WRAP 12'h232
`define PSF_ADDR_C_FLAGS 12'h31c
`define PSF_ADDR_C_ENABLE 12'h31d
`define PSF_ADDR_C_WRAP 12'h31e
`define PSF_FLAGS_RESET 8'h00
`define PSF_ENABLE_RESET 8'h00
`define PSF_WRAP_RESET 8'h00
`define PSF_FLAGS_MASK 8'h3f
`define PSF_ENABLE_WR_MASK 8'h3f
`define PSF_WRAP_MASK 8'h1f
`define PSF_BIT_HIGH_CURRENT 0
`define PSF_BIT_HIGH_VOLTAGE 1
`define PSF_BIT_LOW_VOLTAGE 2
`define PSF_BIT_MISSING_CROSSING 3
`define PSF_BIT_REAL_DIR 4
`define PSF_BIT_REACTIVE_DIR 5
`define PSF_BIT_REAL_DIR_STATUS 6
`define PSF_BIT_REACTIVE_DIR_STATUS 7
`define PSF_FULL_SCALE 17'h10000
`endif

// ==== rtl/psf_phase.v ====
// One phase: condition flags, enable bits, direction status and wrap flags.
// Assumes events are one-cycle pulses in the core clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "psf_consts.vh"
module psf_phase (
   input wire clk,
   input wire rst,
   input wire [5:0] cond_event,
   input wire [4:0] wrap_event,
   input wire real_dir_neg,
   input wire reactive_dir_neg,
   input wire flags_clr,
   input wire wrap_clr,
   input wire enable_wr,
   input wire [7:0] wdata,
   output reg [7:0] flags,
   output reg [7:0] enable,
   output reg [7:0] wrap,
   output reg [5:0] fwd_event
);
   always @(posedge clk) begin
      if (rst) begin
         flags <= `PSF_FLAGS_RESET;
         enable <= `PSF_ENABLE_RESET;
         wrap <= `PSF_WRAP_RESET;
         fwd_event <= 6'h00;
      end else begin
         // Host write of 1 clears; a new event in the same cycle wins.
         flags <= ((flags & ~({8{flags_clr}} & wdata)) | {2'h0, cond_event})
                  & `PSF_FLAGS_MASK;
         // Wrap flags are sticky until the host clears them.
         wrap <= ((wrap & ~({8{wrap_clr}} & wdata)) | {3'h0, wrap_event})
                 & `PSF_WRAP_MASK;
         // Direction status follows the live sign; 1 means negative flow.
         enable[`PSF_BIT_REACTIVE_DIR_STATUS] <= reactive_dir_neg;
         enable[`PSF_BIT_REAL_DIR_STATUS] <= real_dir_neg;
         if (enable_wr) begin
            enable[5:0] <= wdata[5:0];
         end
         // Only enabled conditions reach the global flags.
         fwd_event <= cond_event & enable[5:0];
      end
   end
endmodule
`default_nettype wire

// ==== rtl/psf_top.v ====
// Per-phase status flag logic for three phases, with line frequency readout.
// Assumes byte register accesses from the serial host engine in the core clock.
// Functional notes
// - Phase condition flags stick until host clears.
// - Bit 5 flags reactive direction change, forwarded.
// - Bit 4 flags real direction change, forwarded.
// - Bit 3 flags missing zero crossing, forwarded.
// - Bit 2 flags low voltage, forwarded.
// - Bit 1 flags high voltage, forwarded.
// - Bit 0 flags high current, forwarded.
// - Enable bits 7,6 show energy direction.
// - Enable bits 0-5 gate global forwarding.
// - Wrap bits set on accumulator rollover.
// - Wrap bits stick until host clears.
// - Line frequency is 16-bit, millihertz units.
// - Thresholds are fractions of full scale.
`timescale 1ns/10ps
`default_nettype none
`include "psf_consts.vh"
module psf_top (
   input wire CLK,
   input wire SYS_RST,
   input wire DSP_TICK,
   input wire [31:0] VRMS_A,
   input wire [31:0] VRMS_B,
   input wire [31:0] VRMS_C,
   input wire [31:0] IRMS_A,
   input wire [31:0] IRMS_B,
   input wire [31:0] IRMS_C,
   input wire [15:0] LOW_VOLTAGE_THRESHOLD,
   input wire [15:0] HIGH_VOLTAGE_THRESHOLD,
   input wire [15:0] HIGH_CURRENT_THRESHOLD,
   input wire [2:0] NO_CROSSING,
   input wire [2:0] REAL_DIR_NEG,
   input wire [2:0] REACTIVE_DIR_NEG,
   input wire [14:0] WRAP_EVENT,
   input wire [15:0] LINE_FREQ_IN,
   input wire REG_WR,
   input wire REG_RD,
   input wire [11:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   output reg [7:0] REG_RDATA,
   output reg REG_RVALID,
   output reg [5:0] GLOBAL_EVENT,
   output reg [5:0] GLOBAL_FLAGS,
   output reg [15:0] LINE_FREQUENCY
);
   reg [2:0] real_dir_q;
   reg [2:0] reactive_dir_q;
   reg dir_valid;
   reg [5:0] cond [0:2];
   reg [5:0] fwd_or;
   reg [7:0] next_rdata;
   reg [15:0] next_freq;
   wire [31:0] vrms [0:2];
   wire [31:0] irms [0:2];
   wire [7:0] flags [0:2];
   wire [7:0] enable [0:2];
   wire [7:0] wrap [0:2];
   wire [5:0] fwd [0:2];
   wire [31:0] lv_limit;
   wire [31:0] hv_limit;
   wire [31:0] hc_limit;
   integer i;

   assign vrms[0] = VRMS_A;
   assign vrms[1] = VRMS_B;
   assign vrms[2] = VRMS_C;
   assign irms[0] = IRMS_A;
   assign irms[1] = IRMS_B;
   assign irms[2] = IRMS_C;

   // Thresholds are 16-bit fractions of 0x10000; RMS values carry 24 fraction bits.
   assign lv_limit = {8'h00, LOW_VOLTAGE_THRESHOLD, 8'h00};
   assign hv_limit = {8'h00, HIGH_VOLTAGE_THRESHOLD, 8'h00};
   assign hc_limit = {8'h00, HIGH_CURRENT_THRESHOLD, 8'h00};

   function [11:0] phase_base;
      input integer p;
      begin
         case (p)
            0: phase_base = `PSF_ADDR_A_FLAGS;
            1: phase_base = `PSF_ADDR_B_FLAGS;
            default: phase_base = `PSF_ADDR_C_FLAGS;
         endcase
      end
   endfunction

   // Conditions are evaluated once per DSP cycle.
   always @* begin
      for (i = 0; i < 3; i = i + 1) begin
         cond[i] = 6'h00;
         if (DSP_TICK) begin
            cond[i][`PSF_BIT_HIGH_CURRENT] = irms[i] > hc_limit;
            cond[i][`PSF_BIT_HIGH_VOLTAGE] = vrms[i] > hv_limit;
            cond[i][`PSF_BIT_LOW_VOLTAGE] = vrms[i] < lv_limit;
            cond[i][`PSF_BIT_MISSING_CROSSING] = NO_CROSSING[i];
            cond[i][`PSF_BIT_REAL_DIR] = dir_valid && (REAL_DIR_NEG[i] != real_dir_q[i]);
            cond[i][`PSF_BIT_REACTIVE_DIR] = dir_valid &&
               (REACTIVE_DIR_NEG[i] != reactive_dir_q[i]);
         end
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         real_dir_q <= 3'h0;
         reactive_dir_q <= 3'h0;
         dir_valid <= 1'b0;
      end else if (DSP_TICK) begin
         real_dir_q <= REAL_DIR_NEG;
         reactive_dir_q <= REACTIVE_DIR_NEG;
         dir_valid <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : ph
         wire [11:0] base;
         assign base = phase_base(g);
         psf_phase u_phase (
            .clk(CLK),
            .rst(SYS_RST),
            .cond_event(cond[g]),
            .wrap_event(WRAP_EVENT[g*5 +: 5]),
            .real_dir_neg(REAL_DIR_NEG[g]),
            .reactive_dir_neg(REACTIVE_DIR_NEG[g]),
            .flags_clr(REG_WR && REG_ADDR == base),
            .wrap_clr(REG_WR && REG_ADDR == base + 12'h002),
            .enable_wr(REG_WR && REG_ADDR == base + 12'h001),
            .wdata(REG_WDATA),
            .flags(flags[g]),
            .enable(enable[g]),
            .wrap(wrap[g]),
            .fwd_event(fwd[g])
         );
      end
   endgenerate

   always @* begin
      fwd_or = fwd[0] | fwd[1] | fwd[2];
   end

   // Read mux; unmapped addresses read zero.
   always @* begin
      next_rdata = 8'h00;
      case (REG_ADDR)
         `PSF_ADDR_LINE_FREQ: next_rdata = LINE_FREQUENCY[7:0];
         `PSF_ADDR_LINE_FREQ + 12'h001: next_rdata = LINE_FREQUENCY[15:8];
         `PSF_ADDR_A_FLAGS: next_rdata = flags[0];
         `PSF_ADDR_A_ENABLE: next_rdata = enable[0];
         `PSF_ADDR_A_WRAP: next_rdata = wrap[0];
         `PSF_ADDR_B_FLAGS: next_rdata = flags[1];
         `PSF_ADDR_B_ENABLE: next_rdata = enable[1];
         `PSF_ADDR_B_WRAP: next_rdata = wrap[1];
         `PSF_ADDR_C_FLAGS: next_rdata = flags[2];
         `PSF_ADDR_C_ENABLE: next_rdata = enable[2];
         `PSF_ADDR_C_WRAP: next_rdata = wrap[2];
         default: next_rdata = 8'h00;
      endcase
   end

   always @* begin
      next_freq = LINE_FREQUENCY;
      if (DSP_TICK) begin
         next_freq = LINE_FREQ_IN;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         REG_RDATA <= 8'h00;
         REG_RVALID <= 1'b0;
         GLOBAL_EVENT <= 6'h00;
         GLOBAL_FLAGS <= 6'h00;
         LINE_FREQUENCY <= 16'h0000;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            REG_RDATA <= next_rdata;
         end
         GLOBAL_EVENT <= fwd_or;
         // Global flags collect forwarded events; only SYS_RST clears them.
         GLOBAL_FLAGS <= GLOBAL_FLAGS | fwd_or;
         LINE_FREQUENCY <= next_freq;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/psf_host.sv ====
// Host model making byte register accesses.
// Assumes strobes are sampled at the rising edge of the core clock.
`timescale 1ns/10ps
`default_nettype none
module psf_host (
   input wire CLK,
   output logic REG_WR,
   output logic REG_RD,
   output logic [11:0] REG_ADDR,
   output logic [7:0] REG_WDATA
);
   logic [7:0] q[$];
   initial begin
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = 12'h000;
      REG_WDATA = 8'h00;
   end
   // A set wrap bit means one full modulus passed since the last reading.
   function automatic logic [32:0] energy_delta(input logic [31:0] prev, input logic [31:0] cur,
      input logic wrapped);
      energy_delta = {1'b0, cur} - {1'b0, prev} + (wrapped ? 33'h100000000 : 33'h000000000);
   endfunction
   // A read notes d as the expected data; idle lines show inverted values.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge CLK);
      #1;
      REG_WR = w;
      REG_RD = !w;
      REG_ADDR = a;
      REG_WDATA = d;
      if (!w) q.push_back(d);
      @(posedge CLK);
      #1;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = ~a;
      REG_WDATA = ~d;
   endtask
endmodule
`default_nettype wire

// ==== testbench/psf_top_properties.sv ====
// Port checker for the phase status block.
// Assumes one core clock and a synchronous active high reset.
`timescale 1ns/10ps
`default_nettype none
module psf_chk (
   input wire CLK,
   input wire SYS_RST,
   input wire DSP_TICK,
   input wire REG_RD,
   input wire [11:0] REG_ADDR,
   input wire [7:0] REG_RDATA,
   input wire REG_RVALID,
   input wire [5:0] GLOBAL_EVENT,
   input wire [5:0] GLOBAL_FLAGS,
   input wire [15:0] LINE_FREQUENCY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   logic [15:0] lf_q;
   always @(posedge CLK) lf_q <= LINE_FREQUENCY;
   sequence rd_lf_s; REG_RD && REG_ADDR == 12'h062; endsequence
   sequence rd_fl_s; REG_RD && REG_ADDR inside {12'h144, 12'h230, 12'h31c}; endsequence
   sequence rd_wr_s; REG_RD && REG_ADDR inside {12'h146, 12'h232, 12'h31e}; endsequence
   rd_answer_a: assert property (REG_RD |=> REG_RVALID)
      else $error("read not answered");
   lf_read_a: assert property (rd_lf_s |=> REG_RDATA == lf_q[7:0])
      else $error("wrong frequency byte");
   lf_hold_a: assert property (!DSP_TICK && !$past(DSP_TICK) |-> $stable(LINE_FREQUENCY))
      else $error("frequency moved without tick");
   flag_rsvd_a: assert property (rd_fl_s |=> REG_RDATA[7:6] == 2'b00)
      else $error("flag reserved bit set");
   wrap_rsvd_a: assert property (rd_wr_s |=> REG_RDATA[7:5] == 3'b000)
      else $error("wrap reserved bit set");
   gflag_keep_a: assert property ((GLOBAL_FLAGS & $past(GLOBAL_FLAGS)) == $past(GLOBAL_FLAGS))
      else $error("global flag dropped");
   gflag_set_a: assert property (GLOBAL_EVENT != 6'h00 |=>
      ($past(GLOBAL_EVENT) & ~GLOBAL_FLAGS) == 6'h00) else $error("global flag not set");
   gevent_tick_a: assert property (GLOBAL_EVENT != 6'h00 |-> $past(DSP_TICK, 2))
      else $error("event without tick");
endmodule
bind psf_top psf_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .DSP_TICK(DSP_TICK), .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
   .GLOBAL_EVENT(GLOBAL_EVENT), .GLOBAL_FLAGS(GLOBAL_FLAGS), .LINE_FREQUENCY(LINE_FREQUENCY));
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the phase status block.
// Assumes a 10 MHz core clock and the host model on the register strobes.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic CLK = 1'b0, SYS_RST = 1'b1, DSP_TICK = 1'b0;
   logic [31:0] vr [0:2] = '{default: 32'h00800000};
   logic [31:0] ir [0:2] = '{default: 32'h00100000};
   logic [2:0] nc = 3'h0, rn = 3'h0, xn = 3'h0;
   logic [14:0] wev = 15'h0000;
   logic [15:0] lfi = 16'h0000;
   logic [31:0] seed = 32'h3fb944d1;
   wire reg_wr, reg_rd, rvalid;
   wire [11:0] reg_addr;
   wire [7:0] reg_wdata, rdata;
   wire [5:0] gev, gfl;
   wire [15:0] lf;
   int err_total = 0, n_checks = 0, cyc = 0;
   psf_host host (.CLK(CLK), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata));
   psf_top DUT (.CLK(CLK), .SYS_RST(SYS_RST), .DSP_TICK(DSP_TICK), .VRMS_A(vr[0]),
      .VRMS_B(vr[1]), .VRMS_C(vr[2]), .IRMS_A(ir[0]), .IRMS_B(ir[1]), .IRMS_C(ir[2]),
      .LOW_VOLTAGE_THRESHOLD(16'h4000), .HIGH_VOLTAGE_THRESHOLD(16'hc000),
      .HIGH_CURRENT_THRESHOLD(16'hc000), .NO_CROSSING(nc), .REAL_DIR_NEG(rn),
      .REACTIVE_DIR_NEG(xn), .WRAP_EVENT(wev), .LINE_FREQ_IN(lfi), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata),
      .REG_RVALID(rvalid), .GLOBAL_EVENT(gev), .GLOBAL_FLAGS(gfl), .LINE_FREQUENCY(lf));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic tick();
      @(posedge CLK);
      #1 DSP_TICK = 1'b1;
      @(posedge CLK);
      #1 DSP_TICK = 0;
   endtask
   // Levels sit well clear of the thresholds scaled to the RMS units.
   task automatic cond(input int p, input int b, input logic on);
      case (b)
         0: ir[p] = on ? 32'h00ff0000 : 32'h00100000;
         1: vr[p] = on ? 32'h00ff0000 : 32'h00800000;
         2: vr[p] = on ? 32'h00010000 : 32'h00800000;
         3: nc[p] = on;
         4: rn[p] = rn[p] ^ on;
         default: xn[p] = xn[p] ^ on;
      endcase
   endtask
   initial forever #50 CLK = ~CLK;
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end else if (rvalid === 1'b1) begin
         check("rdata", rdata, host.q.pop_front());
      end
   end
   initial begin
      logic [11:0] a;
      logic [7:0] m, r;
      repeat (5) @(posedge CLK);
      #1 SYS_RST = 1'b0;
      host.xfer(0, 12'h000, 8'h00);
      tick();
      for (int p = 0; p < 3; p++) begin
         a = 12'h144 + 12'hec * 12'(p);
         for (int k = 0; k < 3; k++) host.xfer(0, a + 12'(k), 8'h00);
         for (int b = 0; b < 6; b++)
            for (int e = 0; e < 2; e++) begin
               m = 8'(e << b);
               host.xfer(1, a + 1, m | 8'hc0);
               host.xfer(0, a + 1, {xn[p], rn[p], m[5:0]});
               cond(p, b, 1'b1);
               tick();
               @(posedge CLK);
               #1 check("global_event", gev, m);
               cond(p, b, 1'b0);
               tick();
               host.xfer(0, a, 8'(1 << b));
               host.xfer(1, a, 8'(1 << b) | 8'hc0);
               host.xfer(0, a, 8'h00);
            end
         r = (8'(rnd()) & 8'h1f) | 8'h01;
         wev = 15'(r) << (5 * p);
         @(posedge CLK);
         #1 wev = 15'h0000;
         tick();
         host.xfer(0, a + 2, r);
         host.xfer(1, a + 2, 8'hff);
         host.xfer(0, a + 2, 8'h00);
         $display("phase %0d test done", p);
      end
      repeat (3) begin
         lfi = 16'(rnd());
         tick();
         @(posedge CLK);
         #1 check("line_frequency", lf, lfi);
         host.xfer(1, 12'h062, ~lfi[7:0]);
         host.xfer(0, 12'h062, lfi[7:0]);
         host.xfer(0, 12'h063, lfi[15:8]);
      end
      $display("line frequency test done");
      repeat (3) @(posedge CLK);
      stop_test();
   end
endmodule
`default_nettype wire
